// File: rtl/gpc_pkg.sv
// Package: constants and types for the grayscale PWM counter
package gpc_pkg;

  localparam int          GPC_CHANNELS  = 16;
  localparam int          GPC_GS_BITS   = 12;
  localparam int          GPC_LATCH_BITS = GPC_CHANNELS * GPC_GS_BITS;
  localparam logic [11:0] GPC_CNT_RESET = 12'h000;
  localparam logic [11:0] GPC_CNT_MAX   = 12'hFFF;
  localparam logic [11:0] GPC_GS_ZERO   = 12'h000;

  // Synchronised copies of the controller pins
  typedef struct packed {
    logic grayscale_clock;
    logic blank;
    logic latch_strobe;
  } gpc_pins_t;

  typedef enum logic [1:0] {
    GPC_ST_BLANKED,
    GPC_ST_FIRST,
    GPC_ST_COUNT,
    GPC_ST_DONE
  } gpc_state_t;

endpackage

// File: rtl/gpc_grayscale_pwm_counter.sv
// Module: grayscale PWM counter and per-channel output compare
`timescale 1ns/100ps
module gpc_grayscale_pwm_counter
  import gpc_pkg::*;
#(
  parameter int CHANNELS = GPC_CHANNELS,
  parameter int GS_BITS  = GPC_GS_BITS
) (
  input  wire logic                          i_clk_sys,
  input  wire logic                          i_reset,
  input  wire logic                          i_grayscale_clock,
  input  wire logic                          i_blank,
  input  wire logic                          i_latch_strobe,
  input  wire logic [CHANNELS*GS_BITS-1:0]   i_gray_data,
  output logic      [CHANNELS-1:0]           o_channel_on,
  output logic      [GS_BITS-1:0]            o_count
);

  // ****************************************
  // Pin synchronisers and edge detection
  // ****************************************
  gpc_pins_t pins_meta_reg;
  gpc_pins_t pins_sync_reg;
  gpc_pins_t pins_prev_reg;
  gpc_pins_t pins_raw;

  assign pins_raw = '{grayscale_clock: i_grayscale_clock, blank: i_blank, latch_strobe: i_latch_strobe};

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      pins_meta_reg <= '{default: 1'b1};
      pins_sync_reg <= '{default: 1'b1};
      pins_prev_reg <= '{default: 1'b1};
    end else begin
      pins_meta_reg <= pins_raw;
      pins_sync_reg <= pins_meta_reg;
      pins_prev_reg <= pins_sync_reg;
    end
  end


  // ****************************************
  // Edge decode
  // ****************************************
  // Rising edge from synchronised and previous copies
  function automatic logic rise_of(
    input logic now_level,
    input logic prev_level
  );
    rise_of = now_level & ~prev_level;
  endfunction

  wire gs_rise     = rise_of(pins_sync_reg.grayscale_clock, pins_prev_reg.grayscale_clock);
  wire strobe_rise = rise_of(pins_sync_reg.latch_strobe, pins_prev_reg.latch_strobe);
  wire blank_high  = pins_sync_reg.blank;

  // ****************************************
  // Grayscale latch
  // ****************************************
  // No reset: contents undefined until the controller loads them
  logic [CHANNELS*GS_BITS-1:0] gray_latch_reg;

  always_ff @(posedge i_clk_sys) begin
    if (strobe_rise) begin
      gray_latch_reg <= i_gray_data;
    end
  end

  // ****************************************
  // Counter state machine
  // ****************************************
  gpc_state_t         state_reg;
  gpc_state_t         state_next;
  logic [GS_BITS-1:0] count_reg;
  logic [GS_BITS-1:0] count_next;
  wire                at_max = (count_reg == GPC_CNT_MAX);

  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    case (state_reg)
      GPC_ST_BLANKED: begin
        count_next = GPC_CNT_RESET;
        if (!blank_high) begin
          state_next = GPC_ST_FIRST;
        end
      end
      GPC_ST_FIRST: begin
        if (gs_rise) begin
          state_next = GPC_ST_COUNT;
        end
      end
      GPC_ST_COUNT: begin
        if (gs_rise) begin
          if (at_max) begin
            state_next = GPC_ST_DONE;
          end else begin
            count_next = count_reg + 1'b1;
          end
        end
      end
      GPC_ST_DONE: begin
        count_next = count_reg;
      end
      default: begin
        state_next = GPC_ST_BLANKED;
        count_next = GPC_CNT_RESET;
      end
    endcase
    if (blank_high) begin
      state_next = GPC_ST_BLANKED;
      count_next = GPC_CNT_RESET;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      state_reg <= GPC_ST_BLANKED;
      count_reg <= GPC_CNT_RESET;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
    end
  end

  // ****************************************
  // Per-channel compare
  // ****************************************
  // Counting state: on while count < value, so on time is value periods
  wire                counting = (state_next == GPC_ST_COUNT);
  logic [CHANNELS-1:0] on_next;

  // Lit while counting, nonzero and count still below value
  function automatic logic channel_lit(
    input logic               in_count,
    input logic [GS_BITS-1:0] value,
    input logic [GS_BITS-1:0] cnt
  );
    channel_lit = in_count
                  && (value != GS_BITS'(GPC_GS_ZERO))
                  && (cnt < value);
  endfunction

  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_ch
      wire [GS_BITS-1:0] value = gray_latch_reg[ch*GS_BITS +: GS_BITS];
      wire               lit   = channel_lit(counting, value, count_next);
      assign on_next[ch] = lit;
    end
  endgenerate

  // ****************************************
  // Output registers
  // ****************************************
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_channel_on <= '0;
    end else begin
      o_channel_on <= on_next;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_count <= GPC_CNT_RESET;
    end else begin
      o_count <= count_reg;
    end
  end

endmodule

// File: dv/gpc_chk.sv
// Port checker for the PWM counter
`timescale 1ns/100ps
module gpc_chk (
  input wire logic         i_clk_sys,
  input wire logic         i_reset,
  input wire logic         i_grayscale_clock,
  input wire logic         i_blank,
  input wire logic         i_latch_strobe,
  input wire logic [191:0] i_gray_data,
  input wire logic [15:0]  o_channel_on,
  input wire logic [11:0]  o_count
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  property p_a; i_blank [*6] |-> !o_channel_on; endproperty
  a_a: assert property (p_a) else $error("on in blank");
  property p_b; i_blank [*6] |-> !o_count; endproperty
  a_b: assert property (p_b) else $error("count in blank");
  property p_c; $changed(o_count) |-> o_count == $past(o_count) + 1 || !o_count; endproperty
  a_c: assert property (p_c) else $error("count step");
  property p_d; (&o_count && !i_blank) [*5] |=> &o_count; endproperty
  a_d: assert property (p_d) else $error("count wrap");
  property p_e; (&o_count) [*2] |-> !o_channel_on; endproperty
  a_e: assert property (p_e) else $error("on at max");
  property p_f; o_count > 1 |-> !(o_channel_on & ~$past(o_channel_on)); endproperty
  a_f: assert property (p_f) else $error("late on");
  property p_g; $rose(o_channel_on[0]) |-> !o_count; endproperty
  a_g: assert property (p_g) else $error("late start");
  property p_h; !i_gray_data[23:12] && !$past(i_gray_data[23:12], 8) |-> !o_channel_on[1]; endproperty
  a_h: assert property (p_h) else $error("zero on");
  c_a: cover property (&o_count);
  c_b: cover property ($rose(o_channel_on[0]));
  c_c: cover property (!i_blank && i_latch_strobe);
endmodule
bind gpc_grayscale_pwm_counter gpc_chk i_gpc_chk (.*);

// File: dv/gpc_ctrl.sv
// Display controller model driving the pins
`timescale 1ns/100ps
module gpc_ctrl (
  input  wire logic    i_clk_sys,
  output logic         o_gs = 1'b0,
  output logic         o_bl = 1'b1,
  output logic         o_st = 1'b0,
  output logic [191:0] o_d = '0
);
  task automatic pulse(ref logic s, input int n);
    s = 1'b1;
    repeat (n) @(negedge i_clk_sys);
    s = 1'b0;
    repeat (n) @(negedge i_clk_sys);
  endtask
  task automatic start(logic [191:0] d);
    o_bl = 1'b1;
    pulse(o_gs, 6);
    o_d = d;
    pulse(o_st, 4);
    o_bl = 1'b0;
    repeat (8) @(negedge i_clk_sys);
  endtask
endmodule

// File: dv/gpc_grayscale_pwm_counter_tb.sv
// Self-checking bench for the PWM counter
`timescale 1ns/100ps
module gpc_grayscale_pwm_counter_tb;
  logic         i_clk_sys = 1'b0, i_reset = 1'b1, i_grayscale_clock, i_blank, i_latch_strobe;
  logic [191:0] i_gray_data, g;
  logic [15:0]  o_channel_on, e;
  logic [11:0]  o_count;
  int           bad_count = 0, compares = 0;
  always #12.5 i_clk_sys = ~i_clk_sys;
  gpc_ctrl i_gpc_ctrl (.i_clk_sys, .o_gs(i_grayscale_clock), .o_bl(i_blank), .o_st(i_latch_strobe),
    .o_d(i_gray_data));
  gpc_grayscale_pwm_counter i_gpc_grayscale_pwm_counter (.*);
  task automatic chk(logic [15:0] x, logic [11:0] n);
    compares++;
    if (o_channel_on !== x || o_count !== n) begin
      bad_count++;
      $display("CHECK FAILED %0t outputs", $time);
    end
  endtask
  task automatic final_report();
    if (bad_count == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic t_sweep();
    g = {12'hFFF, 12'hFFE, 12'h801, 12'h800, 12'h7FF, {9{12'h003}}, 12'h000, 12'h001};
    i_gpc_ctrl.start(g);
    chk('0, '0);
    for (int k = 1; k < 4098; k++) begin
      i_gpc_ctrl.pulse(i_gpc_ctrl.o_gs, 6);
      for (int c = 0; c < 16; c++) e[c] = k <= g[12*c+:12];
      chk(e, 12'(k > 4096 ? 4095 : k - 1));
    end
  endtask
  task automatic t_mid();
    i_gpc_ctrl.start({16{12'h008}});
    i_gpc_ctrl.pulse(i_gpc_ctrl.o_gs, 6);
    chk('1, '0);
    i_gpc_ctrl.pulse(i_gpc_ctrl.o_gs, 6);
    i_gpc_ctrl.o_d = '0;
    i_gpc_ctrl.pulse(i_gpc_ctrl.o_st, 4);
    chk('0, 12'h001);
  endtask
  initial begin
    repeat (10) @(negedge i_clk_sys);
    i_reset = 1'b0;
    t_sweep();
    t_mid();
    final_report();
  end
  initial begin
    repeat (60000) @(posedge i_clk_sys);
    bad_count++;
    final_report();
  end
endmodule
